// File: design/tof_pkg.sv
package tof_pkg;

  // ----------------------------------------------------------------
  // Register map (printed offsets are not all multiples of four, so the
  // printed value is an index and the byte address is four times it)
  // ----------------------------------------------------------------
  localparam logic [7:0]  TOF_IDX_MUX      = 8'h13;
  localparam logic [7:0]  TOF_IDX_RNDHOLD  = 8'h14;
  localparam logic [7:0]  TOF_IDX_CKSUM    = 8'h15;
  localparam logic [7:0]  TOF_IDX_TEST     = 8'h16;
  localparam logic [11:0] TOF_ADDR_MUX     = {2'b00, TOF_IDX_MUX, 2'b00};
  localparam logic [11:0] TOF_ADDR_RNDHOLD = {2'b00, TOF_IDX_RNDHOLD, 2'b00};
  localparam logic [11:0] TOF_ADDR_CKSUM   = {2'b00, TOF_IDX_CKSUM, 2'b00};
  localparam logic [11:0] TOF_ADDR_TEST    = {2'b00, TOF_IDX_TEST, 2'b00};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TOF_MUX_SYNC_LSB = 0;
  localparam int TOF_MUX_D_LSB    = 4;
  localparam int TOF_MUX_C_LSB    = 9;
  localparam int TOF_MUX_B_LSB    = 12;
  localparam int TOF_RH_RNDAB_LSB = 0;
  localparam int TOF_RH_OFFBIN    = 3;
  localparam int TOF_RH_HCAB      = 4;
  localparam int TOF_RH_HOLD_LSB  = 5;
  localparam int TOF_RH_RNDCD_LSB = 8;
  localparam int TOF_RH_QUIETCD   = 10;
  localparam int TOF_RH_HCCD      = 11;
  localparam int TOF_RH_XMTCD     = 12;
  localparam int TOF_RH_SUMIN     = 13;
  localparam int TOF_RH_XMTAB     = 14;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] TOF_MUX_RST     = 16'h0007;
  localparam logic [15:0] TOF_RNDHOLD_RST = 16'h0000;
  localparam logic [15:0] TOF_TEST_RST    = 16'h0000;
  localparam logic [15:0] TOF_CKSUM_RST   = 16'h0000;
  localparam logic [15:0] TOF_LFSR_SEED   = 16'hace1;
  localparam int          TOF_FIFO_DEPTH  = 16;

  // Port D source codes.
  localparam logic [4:0] TOF_D_QUIET = 5'h00;
  localparam logic [4:0] TOF_D_ID    = 5'h01;
  localparam logic [4:0] TOF_D_QB    = 5'h02;
  localparam logic [4:0] TOF_D_IBLSB = 5'h04;
  localparam logic [4:0] TOF_D_QALSB = 5'h08;
  localparam logic [4:0] TOF_D_CCMP  = 5'h10;

  typedef struct packed {
    logic [15:0] ia;
    logic [15:0] qa;
    logic [15:0] ib;
    logic [15:0] qb;
    logic [15:0] ic;
    logic [15:0] qc;
    logic [15:0] id;
    logic [15:0] qd;
  } tof_chan_s;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    logic [15:0] d;
  } tof_ports_s;

endpackage

// File: design/tof_fifo.sv
`timescale 1ns/1ps
module tof_fifo
#(
  parameter int WIDTH = 128,
  parameter int DEPTH = 16
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } tof_fifo_s;

  tof_fifo_s        st;
  tof_fifo_s        next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data  = mem[st.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.wp = st.wp + 1'b1;
    end
    if (pop)
    begin
      next_st.rp = st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      mem[st.wp] <= in_data;
    end
  end

  a_fifo_no_over: assert property (@(posedge pclk) disable iff (!presetn)
    st.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

// File: design/tof_formatter.sv
`timescale 1ns/1ps
// Contract
// - Port D selects quiet, id, qb, ib low bits, qa low bits, or not-C.
// - Port C selects quiet, ic, ib or qa by codes 0, 1, 2, 4.
// - Port B selects quiet, ib, qa, ia low bit, or not-A.
// - Hold counter restarts by a three-bit sync select, default 7.
// - Ports A and B round to 16, 14, 12 bits or none.
// - Ports C and D round by one shared code, separate from A/B.
// - One bit picks offset binary or two's complement, default two's.
// - A/B interleave puts I then Q on A/B, halving the rate.
// - Each output sample is held hold plus one clocks; default zero.
// - Quiet bit silences the C/D output path.
// - C/D interleave time-multiplexes I and Q on C and D.
// - C/D direction bit: transmit when set, receive when clear.
// - Sum-input bit makes ports C and D inputs, else outputs.
// - A/B direction bit: transmit when set, receive when clear.
// - Sixteen-bit checksum register is read only.
// - Self-test uses pattern generator, timer sync and checksum compressor.
module tof_formatter
  import tof_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire tof_chan_s   chan_data,
  input  wire logic        chan_valid,
  output logic             chan_ready,
  input  wire logic [2:0]  sync_in,
  input  wire logic [15:0] port_c_in,
  input  wire logic [15:0] port_d_in,
  output logic      [15:0] output_port_a,
  output logic      [15:0] output_port_b,
  output logic      [15:0] output_port_c,
  output logic      [15:0] output_port_d,
  output logic             port_cd_oen,
  output logic      [31:0] sum_in_data,
  output logic             transmit_dir_pair_ab,
  output logic             transmit_dir_pair_cd
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] mux;
    logic [15:0] rh;
    logic [15:0] test;
    logic [15:0] cksum;
    logic [15:0] lfsr;
    logic [2:0]  hold_cnt;
    logic        phase;
    tof_ports_s  outp;
    logic        oen;
    logic [31:0] sumin;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic [2:0]  sync_q1;
    logic [2:0]  sync_q2;
    logic [31:0] cd_q1;
    logic [31:0] cd_q2;
    logic [3:0]  cfg_age;
  } tof_state_s;

  tof_state_s st;
  tof_state_s next_st;

  logic [2:0]  hold_sync_sel;
  logic [4:0]  port_d_source_select;
  logic [2:0]  port_c_source_select;
  logic [3:0]  port_b_source_select;
  logic [1:0]  round_width_pair_ab;
  logic [1:0]  round_width_pair_cd;
  logic        offset_binary;
  logic        iq_interleave_pair_ab;
  logic        iq_interleave_pair_cd;
  logic [2:0]  hold_len;
  logic        silence_pair_cd;
  logic        sum_input_mode;
  logic        self_test;
  tof_chan_s   fifo_data;
  logic        fifo_valid;
  logic        fifo_ready;
  tof_chan_s   src;
  logic        restart;
  logic        take;
  logic        access;
  logic [11:0] word_addr;
  tof_ports_s  raw;
  tof_ports_s  fmt;

  assign hold_sync_sel         = st.mux[TOF_MUX_SYNC_LSB +: 3];
  assign port_d_source_select  = st.mux[TOF_MUX_D_LSB +: 5];
  assign port_c_source_select  = st.mux[TOF_MUX_C_LSB +: 3];
  assign port_b_source_select  = st.mux[TOF_MUX_B_LSB +: 4];
  assign round_width_pair_ab   = st.rh[TOF_RH_RNDAB_LSB +: 2];
  assign round_width_pair_cd   = st.rh[TOF_RH_RNDCD_LSB +: 2];
  assign offset_binary         = st.rh[TOF_RH_OFFBIN];
  assign iq_interleave_pair_ab = st.rh[TOF_RH_HCAB];
  assign iq_interleave_pair_cd = st.rh[TOF_RH_HCCD];
  assign hold_len              = st.rh[TOF_RH_HOLD_LSB +: 3];
  assign silence_pair_cd       = st.rh[TOF_RH_QUIETCD];
  assign sum_input_mode        = st.rh[TOF_RH_SUMIN];
  assign self_test             = st.test[0];

  // ----------------------------------------------------------------
  // Sample buffer
  // ----------------------------------------------------------------
  tof_fifo #(.WIDTH($bits(tof_chan_s)), .DEPTH(TOF_FIFO_DEPTH)) u_fifo
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_data   (chan_data),
    .in_valid  (chan_valid),
    .in_ready  (chan_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );

  // Round to the chosen width with saturation, then clear the low bits.
  function automatic logic [15:0] tof_round(input logic [15:0] v,
                                            input logic [1:0]  code);
    logic [16:0] sum;
    logic [15:0] half;
    logic [15:0] keep;
    half = 16'h0000;
    keep = 16'hffff;
    case (code)
      2'h2:
      begin
        half = 16'h0002;
        keep = 16'hfffc;
      end
      2'h3:
      begin
        half = 16'h0008;
        keep = 16'hfff0;
      end
      default:
      begin
        half = 16'h0000;
        keep = 16'hffff;
      end
    endcase
    sum = {v[15], v} + {1'b0, half};
    if (sum[16] != sum[15])
    begin
      tof_round = 16'h7fff & keep;
    end
    else
    begin
      tof_round = sum[15:0] & keep;
    end
  endfunction

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  always_comb
  begin
    src = fifo_data;
    if (self_test)
    begin
      src = {8{st.lfsr}};
    end
    // A sync restarts the hold counter; 7 in the select means none.
    restart = (hold_sync_sel != 3'h7) && st.sync_q2[hold_sync_sel[1:0]];
    take = restart || (st.hold_cnt == hold_len);
    fifo_ready = take && !self_test;
    raw.a = (iq_interleave_pair_ab && st.phase) ? src.qa : src.ia;
    raw.b = (iq_interleave_pair_ab && st.phase) ? src.qb : src.ib;
    case (port_c_source_select)
      3'h1: raw.c = src.ic;
      3'h2: raw.c = src.ib;
      3'h4: raw.c = src.qa;
      default: raw.c = 16'h0000;
    endcase
    if (iq_interleave_pair_cd && st.phase && port_c_source_select == 3'h1)
    begin
      raw.c = src.qc;
    end
    case (port_b_source_select)
      4'h1: raw.b = iq_interleave_pair_ab && st.phase ? src.qb : src.ib;
      4'h2: raw.b = src.qa;
      4'h4: raw.b = {15'h0000, src.ia[0]};
      4'h8: raw.b = ~raw.a;
      default: raw.b = 16'h0000;
    endcase
    fmt.a = tof_round(raw.a, round_width_pair_ab);
    fmt.b = tof_round(raw.b, round_width_pair_ab);
    fmt.c = tof_round(raw.c, round_width_pair_cd);
    case (port_d_source_select)
      TOF_D_ID:    raw.d = (iq_interleave_pair_cd && st.phase) ? src.qd
                                                               : src.id;
      TOF_D_QB:    raw.d = src.qb;
      TOF_D_IBLSB: raw.d = {8'h00, src.ib[7:0]};
      TOF_D_QALSB: raw.d = {8'h00, src.qa[7:0]};
      TOF_D_CCMP:  raw.d = ~fmt.c;
      default:     raw.d = 16'h0000;
    endcase
    fmt.d = tof_round(raw.d, round_width_pair_cd);
    if (offset_binary)
    begin
      fmt.a[15] = ~fmt.a[15];
      fmt.b[15] = ~fmt.b[15];
      fmt.c[15] = ~fmt.c[15];
      fmt.d[15] = ~fmt.d[15];
    end
    if (silence_pair_cd)
    begin
      fmt.c = 16'h0000;
      fmt.d = 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Register bus and state update
  // ----------------------------------------------------------------
  assign access    = psel && penable;
  assign word_addr = {2'b00, paddr[11:2]};

  always_comb
  begin
    next_st = st;
    next_st.sync_q1 = sync_in;
    next_st.sync_q2 = st.sync_q1;
    next_st.cd_q1 = {port_c_in, port_d_in};
    next_st.cd_q2 = st.cd_q1;
    next_st.hold_cnt = take ? 3'h0 : st.hold_cnt + 3'h1;
    if (take && (self_test || fifo_valid))
    begin
      next_st.outp = fmt;
      next_st.phase = restart ? 1'b0 : ~st.phase;
      next_st.lfsr = {st.lfsr[14:0],
                      st.lfsr[15] ^ st.lfsr[13] ^ st.lfsr[12] ^ st.lfsr[10]};
      // The checksum folds every new output word so one compare covers all.
      next_st.cksum = {st.cksum[14:0], st.cksum[15]}
                      ^ fmt.a ^ fmt.b ^ fmt.c ^ fmt.d;
    end
    next_st.oen = sum_input_mode;
    next_st.sumin = st.cd_q2;
    next_st.ready = psel && !penable;
    next_st.err = 1'b0;
    next_st.rdata = 32'h0000_0000;
    if (psel && !penable)
    begin
      next_st.err = !(word_addr == {4'h0, TOF_IDX_MUX}
                   || word_addr == {4'h0, TOF_IDX_RNDHOLD}
                   || word_addr == {4'h0, TOF_IDX_CKSUM}
                   || word_addr == {4'h0, TOF_IDX_TEST});
      case (word_addr)
        {4'h0, TOF_IDX_MUX}:     next_st.rdata = {16'h0000, st.mux};
        {4'h0, TOF_IDX_RNDHOLD}: next_st.rdata = {16'h0000, st.rh};
        {4'h0, TOF_IDX_CKSUM}:   next_st.rdata = {16'h0000, st.cksum};
        {4'h0, TOF_IDX_TEST}:    next_st.rdata = {16'h0000, st.test};
        default:                 next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (access && pwrite && st.ready)
    begin
      case (word_addr)
        {4'h0, TOF_IDX_MUX}:     next_st.mux = pwdata[15:0];
        {4'h0, TOF_IDX_RNDHOLD}: next_st.rh = pwdata[15:0];
        {4'h0, TOF_IDX_TEST}:    next_st.test = {15'h0000, pwdata[0]};
        default:                 next_st.err = 1'b0;
      endcase
    end
    // Cycles since the last configuration change. The hold counter may
    // wrap once before it settles, so the period check waits on this.
    if (next_st.rh != st.rh || next_st.mux != st.mux)
    begin
      next_st.cfg_age = 4'h0;
    end
    else if (st.cfg_age != 4'hf)
    begin
      next_st.cfg_age = st.cfg_age + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.mux <= TOF_MUX_RST;
      st.rh <= TOF_RNDHOLD_RST;
      st.test <= TOF_TEST_RST;
      st.cksum <= TOF_CKSUM_RST;
      st.lfsr <= TOF_LFSR_SEED;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign output_port_a        = st.outp.a;
  assign output_port_b        = st.outp.b;
  assign output_port_c        = st.outp.c;
  assign output_port_d        = st.outp.d;
  assign port_cd_oen          = st.oen;
  assign sum_in_data          = st.sumin;
  assign transmit_dir_pair_ab = st.rh[TOF_RH_XMTAB];
  assign transmit_dir_pair_cd = st.rh[TOF_RH_XMTCD];
  assign prdata               = st.rdata;
  assign pready               = st.ready;
  assign pslverr              = st.err;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_cksum_ro_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && pready && word_addr == {4'h0, TOF_IDX_CKSUM}
     && !(take && (self_test || fifo_valid))) |=> $stable(st.cksum))
    else $error("checksum changed by a write");
  a_quiet_cd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (silence_pair_cd && take && fifo_valid) |=> output_port_c == 16'h0000)
    else $error("quiet C/D path not silent");
  a_hold_period: assert property (@(posedge pclk) disable iff (!presetn)
    (hold_sync_sel == 3'h7 && hold_len == 3'h2 && take
     && st.cfg_age >= 4'ha) |-> (!$past(take, 1) && !$past(take, 2)
     && $past(take, 3)))
    else $error("hold period wrong");
  a_sumin_dir: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sum_input_mode) |=> port_cd_oen)
    else $error("C/D direction not following sum-input");
  a_dir_ab_out: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && pready && word_addr == {4'h0, TOF_IDX_RNDHOLD})
    |=> transmit_dir_pair_ab == $past(pwdata[TOF_RH_XMTAB]))
    else $error("A/B direction mismatch");
  a_dir_cd_out: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && pready && word_addr == {4'h0, TOF_IDX_RNDHOLD})
    |=> transmit_dir_pair_cd == $past(pwdata[TOF_RH_XMTCD]))
    else $error("C/D direction mismatch");
  a_round_lsb_12: assert property (@(posedge pclk) disable iff (!presetn)
    (round_width_pair_ab == 2'h3 && take && fifo_valid && !offset_binary)
    |=> output_port_a[3:0] == 4'h0)
    else $error("A not rounded to 12 bits");
  a_port_c_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (port_c_source_select == 3'h0 && take && fifo_valid && !offset_binary)
    |=> output_port_c == 16'h0000)
    else $error("C not quiet for code 0");
  a_pready_once: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("pready not one cycle");
endmodule

// File: test/tof_dac_model.sv
`timescale 1ns/1ps
module tof_dac_model
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] output_port_a,
  input  wire logic [15:0] output_port_c,
  input  wire logic        port_cd_oen,
  output logic      [15:0] port_c_in,
  output logic      [15:0] port_d_in,
  output logic      [15:0] prev_a,
  output logic      [15:0] prev_c,
  output logic      [7:0]  gap_a
);
  logic [15:0] last_a;
  logic [15:0] last_c;
  logic [7:0]  run;

  // ----------------------------------------------------------------
  // Capture side
  // ----------------------------------------------------------------
  // Released lines toggle every cycle, so a stale sum-in word is
  // never mistaken for one that the model really drives.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_c_in <= 16'h0000;
      port_d_in <= 16'h0000;
      last_a    <= 16'h0000;
      last_c    <= 16'h0000;
      prev_a    <= 16'h0000;
      prev_c    <= 16'h0000;
      run       <= 8'h00;
      gap_a     <= 8'h00;
    end
    else
    begin
      port_c_in <= port_cd_oen ? 16'h5a5a : ~port_c_in;
      port_d_in <= port_cd_oen ? 16'ha5a5 : ~port_d_in;
      run       <= (output_port_a != last_a) ? 8'h01 : run + 8'h01;
      if (output_port_a != last_a)
      begin
        gap_a  <= run;
        prev_a <= last_a;
      end
      if (output_port_c != last_c)
      begin
        prev_c <= last_c;
      end
      last_a <= output_port_a;
      last_c <= output_port_c;
    end
  end
endmodule

// File: test/tof_formatter_tb_top.sv
`timescale 1ns/1ps
module tof_formatter_tb_top;
  import tof_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  tof_chan_s   chan_data;
  logic        chan_valid;
  logic        chan_ready;
  logic [2:0]  sync_in;
  logic [15:0] port_c_in;
  logic [15:0] port_d_in;
  logic [15:0] output_port_a;
  logic [15:0] output_port_b;
  logic [15:0] output_port_c;
  logic [15:0] output_port_d;
  logic        port_cd_oen;
  logic [31:0] sum_in_data;
  logic        dir_ab;
  logic        dir_cd;
  logic [15:0] prev_a;
  logic [15:0] prev_c;
  logic [7:0]  gap_a;
  logic [31:0] rdata;
  logic [31:0] ck0;
  logic        rerr;
  logic        saw;
  tof_chan_s   smp;
  int          failures;
  int          num_checks;

  tof_formatter u_tof_formatter (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_data(chan_data), .chan_valid(chan_valid),
    .chan_ready(chan_ready), .sync_in(sync_in), .port_c_in(port_c_in),
    .port_d_in(port_d_in), .output_port_a(output_port_a),
    .output_port_b(output_port_b), .output_port_c(output_port_c),
    .output_port_d(output_port_d), .port_cd_oen(port_cd_oen),
    .sum_in_data(sum_in_data), .transmit_dir_pair_ab(dir_ab),
    .transmit_dir_pair_cd(dir_cd));

  tof_dac_model u_tof_dac_model (.pclk(pclk), .presetn(presetn),
    .output_port_a(output_port_a), .output_port_c(output_port_c),
    .port_cd_oen(port_cd_oen), .port_c_in(port_c_in),
    .port_d_in(port_d_in), .prev_a(prev_a), .prev_c(prev_c),
    .gap_a(gap_a));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // The master never assumes a latency; only the watchdog ends a wait.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, rdata, exp);
  endtask

  task automatic send(input tof_chan_s s);
    @(posedge pclk);
    chan_data  <= s;
    chan_valid <= 1'b1;
    do @(posedge pclk); while (chan_ready !== 1'b1);
    chan_valid <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask

  function automatic logic [31:0] mx(input logic [3:0] b,
                                     input logic [2:0] c,
                                     input logic [4:0] d);
    return {16'h0000, b, c, d, 1'b0, 3'h7};
  endfunction

  task automatic mcase(input logic [3:0] b, input logic [2:0] c,
                       input logic [4:0] d, input logic [15:0] eb,
                       input logic [15:0] mb, input logic [15:0] ec,
                       input logic [15:0] ed, input logic [15:0] md);
    wr(TOF_ADDR_MUX, mx(b, c, d));
    send(smp);
    check("port_b", {16'h0, output_port_b & mb}, {16'h0, eb & mb});
    check("port_c", {16'h0, output_port_c}, {16'h0, ec});
    check("port_d", {16'h0, output_port_d & md}, {16'h0, ed & md});
  endtask

  // ----------------------------------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial
  begin
    #200000;
    failures++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    failures = 0;
    num_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    chan_data = '0;
    chan_valid = 1'b0;
    sync_in = 3'h0;
    smp = '{16'h1236, 16'h2a5c, 16'h3c01, 16'h4d02,
            16'h7ffe, 16'h0e03, 16'h6f04, 16'h0105};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("mux_rst", TOF_ADDR_MUX, 32'h7);
    rdchk("rh_rst", TOF_ADDR_RNDHOLD, 32'h0);
    rdchk("ck_rst", TOF_ADDR_CKSUM, 32'h0);
    wr(TOF_ADDR_CKSUM, 32'hffff);
    rdchk("ck_ro", TOF_ADDR_CKSUM, 32'h0);
    wr(TOF_ADDR_RNDHOLD, 32'h7fff);
    rdchk("rh_rw", TOF_ADDR_RNDHOLD, 32'h7fff);
    wr(TOF_ADDR_RNDHOLD, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped_err", {31'h0, rerr}, 32'h1);
    check("unmapped_data", rdata, 32'h0);
    mcase(1, 1, 1, smp.ib, 16'hffff, smp.ic, smp.id, 16'hffff);
    check("port_a", {16'h0, output_port_a}, {16'h0, smp.ia});
    mcase(2, 2, 2, smp.qa, 16'hffff, smp.ib, smp.qb, 16'hffff);
    mcase(4, 4, 4, smp.ia, 16'h0001, smp.qa, smp.ib, 16'h00ff);
    mcase(8, 0, 8, ~smp.ia, 16'hffff, 16'h0, smp.qa, 16'h00ff);
    mcase(0, 1, 16, 16'h0, 16'hffff, smp.ic, ~smp.ic, 16'hffff);
    wr(TOF_ADDR_MUX, mx(1, 1, 1));
    wr(TOF_ADDR_RNDHOLD, 32'h2);
    send(smp);
    check("rnd14_a", {16'h0, output_port_a}, 32'h1238);
    check("rnd0_c", {16'h0, output_port_c}, 32'h7ffe);
    wr(TOF_ADDR_RNDHOLD, 32'h200);
    send(smp);
    check("rnd0_a", {16'h0, output_port_a}, 32'h1236);
    check("sat_c", {16'h0, output_port_c}, 32'h7ffc);
    wr(TOF_ADDR_RNDHOLD, 32'h3);
    send(smp);
    check("rnd12_a", {16'h0, output_port_a}, 32'h1230);
    wr(TOF_ADDR_RNDHOLD, 32'h8);
    send(smp);
    check("offbin_a", {16'h0, output_port_a}, 32'h9236);
    check("offbin_d", {16'h0, output_port_d}, 32'hef04);
    wr(TOF_ADDR_RNDHOLD, 32'h5400);
    send(smp);
    check("quiet_c", {16'h0, output_port_c}, 32'h0);
    check("quiet_d", {16'h0, output_port_d}, 32'h0);
    check("dir_ab", {31'h0, dir_ab}, 32'h1);
    check("dir_cd", {31'h0, dir_cd}, 32'h1);
    wr(TOF_ADDR_RNDHOLD, 32'h2000);
    repeat (8) @(posedge pclk);
    check("oen_in", {31'h0, port_cd_oen}, 32'h1);
    check("sum_in", sum_in_data, 32'h5a5aa5a5);
    check("dir_ab0", {31'h0, dir_ab}, 32'h0);
    check("dir_cd0", {31'h0, dir_cd}, 32'h0);
    wr(TOF_ADDR_RNDHOLD, 32'h0);
    repeat (4) @(posedge pclk);
    check("oen_out", {31'h0, port_cd_oen}, 32'h0);
    wr(TOF_ADDR_RNDHOLD, 32'h0810);
    smp.ia = 16'h1111;
    smp.qa = 16'h2222;
    smp.ic = 16'h3333;
    smp.qc = 16'h4444;
    // Ten earlier words leave the phase at I; each word yields I or Q.
    send(smp);
    send(smp);
    check("hc_ab_i", {16'h0, prev_a}, 32'h1111);
    check("hc_ab_q", {16'h0, output_port_a}, 32'h2222);
    check("hc_cd_i", {16'h0, prev_c}, 32'h3333);
    check("hc_cd_q", {16'h0, output_port_c}, 32'h4444);
    wr(TOF_ADDR_RNDHOLD, 32'h40);
    // Back-to-back pushes, so the hold counter and not the bench paces.
    for (int i = 0; i < 4; i++)
    begin
      smp.ia = 16'h0100 + 16'(i);
      chan_data  <= smp;
      chan_valid <= 1'b1;
      do @(posedge pclk); while (chan_ready !== 1'b1);
    end
    chan_valid <= 1'b0;
    repeat (24) @(posedge pclk);
    check("hold_gap", {24'h0, gap_a}, 32'h3);
    // Slowest hold, so the buffer has to refuse while it drains.
    wr(TOF_ADDR_RNDHOLD, 32'he0);
    saw = 1'b0;
    @(posedge pclk);
    chan_valid <= 1'b1;
    repeat (60)
    begin
      @(posedge pclk);
      if (chan_ready === 1'b0)
        saw = 1'b1;
    end
    chan_valid <= 1'b0;
    check("fifo_full", {31'h0, saw}, 32'h1);
    repeat (200) @(posedge pclk);
    check("fifo_empty", {31'h0, chan_ready}, 32'h1);
    apb(1'b0, TOF_ADDR_CKSUM, 32'h0);
    ck0 = rdata;
    // Host side of self-test: patterns on, let them run, then read back.
    wr(TOF_ADDR_TEST, 32'h1);
    repeat (100) @(posedge pclk);
    apb(1'b0, TOF_ADDR_CKSUM, 32'h0);
    check("cksum_run", {31'h0, rdata != ck0}, 32'h1);
    wr(TOF_ADDR_TEST, 32'h0);
    end_of_test();
  end
endmodule
